// >>> sim/tb_top.sv
// bench for the pin control block
// assumes the modem stand-in answers after a short lag
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ucpc_pkg::*;
    logic i_clock = 0, i_rst_n = 0, i_reset_pin = 0, i_wr = 0, i_rd = 0, o_int;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, rd_val;
    logic [9:0] i_rx_count = 10'h000, i_tx_count = 10'h200, i_rx_trigger = 10'h000;
    logic [1:0] i_tx_serial = 2'h3, i_rx_serial_pin = 2'h3, carrier = 2'h2, i_cts_n, i_dsr_n, i_carrier_detect_in_n;
    logic [1:0] o_dtr_n, o_rts_n, o_user_output_two_n, o_irq, o_irq_oe, o_rx_ready_n, o_tx_ready_n, o_tx_pin, o_rx_serial;
    logic [4:0] rx_tab [5] = '{5'h00, 5'h03, 5'h04, 5'h01, 5'h10}, tr_tab [5] = '{5'h00, 5'h04, 5'h04, 5'h00, 5'h10};
    logic [4:0] tx_tab [5] = '{5'h0f, 5'h10, 5'h00, 5'h10, 5'h01};
    int err_total = 0, total_checks = 0;
    wire [7:0] pins = {o_dtr_n, o_rts_n, o_user_output_two_n, o_irq_oe};
    ucpc_top #(.FIFO_DEPTH(16)) i_dut (.i_clock, .i_rst_n, .i_reset_pin, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_rx_count, .i_tx_count, .i_rx_trigger, .i_rx_line_err(2'h0), .i_tx_serial, .i_rx_serial_pin, .i_cts_n,
        .i_dsr_n, .i_ri_n(2'h3), .i_carrier_detect_in_n, .o_dtr_n, .o_rts_n, .o_user_output_two_n, .o_irq,
        .o_irq_oe, .o_rx_ready_n, .o_tx_ready_n, .o_tx_pin, .o_rx_serial, .o_int);
    ucpc_modem #(.LAG(3)) i_modem (.i_clock, .i_dtr_n(o_dtr_n), .i_rts_n(o_rts_n), .i_carrier(carrier),
        .o_cts_n(i_cts_n), .o_dsr_n(i_dsr_n), .o_cd_n(i_carrier_detect_in_n));
    // 25 MHz clock
    initial forever #20 i_clock = ~i_clock;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
        wait_cyc(2);
    endtask
    task automatic reg_rd(input logic [3:0] a);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(posedge i_clock);
        rd_val = o_rdata;
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // main sequence
    initial begin
        wait_cyc(6);
        i_rst_n <= 1'b1;
        wait_cyc(1);
        check(pins, 8'hfc);
        reg_wr(UCPC_OFF_MCTL, 8'h0b);
        check(pins, 8'ha9);
        reg_wr(UCPC_OFF_MCTL, 8'h00);
        reg_wr(UCPC_CH_STRIDE | UCPC_OFF_MCTL, 8'h02);
        check(pins, 8'hdc);
        wait_cyc(6);
        reg_rd(UCPC_CH_STRIDE | UCPC_OFF_MSTAT);
        check(rd_val & 8'hf0, 8'h90);
        reg_rd(UCPC_OFF_MSTAT);
        check(rd_val & 8'hf0, 8'h00);
        for (int k = 0; k < 5; k++) begin
            i_rx_count[4:0] <= rx_tab[k];
            i_rx_trigger[4:0] <= tr_tab[k];
            i_tx_count[4:0] <= tx_tab[k];
            wait_cyc(2);
            check({4'h0, o_rx_ready_n, o_tx_ready_n}, {5'h01, !(rx_tab[k] != 5'h00 && rx_tab[k] >= tr_tab[k]),
                1'b1, tx_tab[k] >= 5'h10});
        end
        i_rx_count[4:0] <= 5'h00;
        reg_wr(UCPC_OFF_IMSK, 8'h01);
        check({7'h00, o_int}, 8'h01);
        reg_wr(UCPC_OFF_IMSK, 8'h00);
        check({7'h00, o_int}, 8'h00);
        reg_wr(UCPC_OFF_IMSK, 8'h01);
        reg_rd(UCPC_OFF_IST);
        check(rd_val & 8'h01, 8'h01);
        wait_cyc(1);
        check({7'h00, o_int}, 8'h00);
        reg_rd(4'h7);
        check(rd_val, 8'h00);
        reg_rd(UCPC_OFF_FST);
        check(rd_val, 8'h02);
        i_rx_count[4:0] <= 5'h02;
        i_rx_trigger[4:0] <= 5'h01;
        reg_wr(UCPC_OFF_IRQ_EN, 8'h01);
        reg_wr(UCPC_OFF_MCTL, 8'h08);
        check({6'h00, o_irq}, 8'h01);
        reg_wr(UCPC_OFF_IRQ_EN, 8'h00);
        check({6'h00, o_irq}, 8'h00);
        i_tx_serial <= 2'h0;
        i_rx_serial_pin <= 2'h0;
        wait_cyc(4);
        check({4'h0, o_tx_pin, o_rx_serial}, 8'h00);
        i_reset_pin <= 1'b1;
        wait_cyc(4);
        check({o_tx_pin, o_rx_serial, o_user_output_two_n, o_irq_oe}, 8'hfc);
        i_reset_pin <= 1'b0;
        wait_cyc(4);
        complete_run;
    end
    // cut a hang short
    initial begin
        wait_cyc(3000);
        err_total++;
        complete_run;
    end
endmodule
`default_nettype wire

// >>> sim/ucpc_modem.sv
// modem stand-in on the serial side
// assumes the bench supplies the carrier state
`timescale 1ns/1ns
`default_nettype none
module ucpc_modem #(
    parameter int LAG = 3
) (
    // requests from the block; carrier state from the bench
    input wire logic i_clock,
    input wire logic [1:0] i_dtr_n, i_rts_n, i_carrier,
    // status lines back
    output logic [1:0] o_cts_n, o_dsr_n, o_cd_n
);
    logic [4*LAG-1:0] pipe_q = '1;
    // requests pass through the modem reaction delay
    always_ff @(posedge i_clock) begin
        pipe_q <= {pipe_q[4*LAG-5:0], i_dtr_n, i_rts_n};
    end
    assign o_dsr_n = pipe_q[4*LAG-1 -: 2];
    assign o_cts_n = pipe_q[4*LAG-3 -: 2];
    assign o_cd_n = ~i_carrier;
endmodule
`default_nettype wire

// >>> sim/ucpc_monitor.sv
// assertion checker for the pin control block
// assumes one clock; watches top-level ports only
`timescale 1ns/1ns
`default_nettype none
module ucpc_monitor #(
    parameter int FIFO_DEPTH = 16
) (
    // clock, resets, register writes
    input wire logic i_clock, i_rst_n, i_reset_pin, i_wr,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    // fifo levels
    input wire logic [9:0] i_rx_count, i_tx_count, i_rx_trigger,
    // pin outputs
    input wire logic [1:0] o_dtr_n, o_rts_n, o_user_output_two_n, o_irq, o_irq_oe,
    input wire logic [1:0] o_rx_ready_n, o_tx_ready_n, o_tx_pin, o_rx_serial
);
    logic [2:0] quiet_ff = 3'h4;
    // hold checks off while a reset settles
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || i_reset_pin)
            quiet_ff <= 3'h4;
        else if (quiet_ff != 3'h0)
            quiet_ff <= quiet_ff - 3'h1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (quiet_ff != 3'h0);
    a_user_out_follows: assert property (i_wr && i_addr == 4'h0 |=> ##1
        o_user_output_two_n[0] == !$past(i_wdata[3], 2)) else $error("user output wrong");
    a_oe_user_pair: assert property (o_irq_oe == ~o_user_output_two_n) else $error("oe user split");
    a_dtr_follows: assert property (i_wr && i_addr == 4'h0 |=> ##1
        o_dtr_n[0] == !$past(i_wdata[0], 2)) else $error("dtr wrong");
    a_rts_chan_b: assert property (i_wr && i_addr == 4'h8 |=> ##1
        o_rts_n[1] == !$past(i_wdata[1], 2)) else $error("rts wrong");
    a_irq_gated: assert property (o_irq[0] |-> o_irq_oe[0]) else $error("irq ungated");
    a_tx_ready_full: assert property (o_tx_ready_n[0] == ($past(i_tx_count[4:0]) >= FIFO_DEPTH))
        else $error("tx ready wrong");
    a_rx_ready_lvl: assert property (o_rx_ready_n[0] == !($past(i_rx_count[4:0]) != 5'h00 &&
        $past(i_rx_count[4:0]) >= $past(i_rx_trigger[4:0]))) else $error("rx ready wrong");
    a_reset_idles: assert property (disable iff (!i_rst_n) i_reset_pin [*4] |->
        o_tx_pin == 2'h3 && o_rx_serial == 2'h3 && o_dtr_n == 2'h3) else $error("reset state wrong");
    c_user_out_on: cover property (i_wr && i_addr == 4'h0 && i_wdata[3]);
    c_irq: cover property (o_irq[0]);
    c_tx_full: cover property (!o_tx_ready_n[0] ##1 o_tx_ready_n[0]);
endmodule
bind ucpc_top ucpc_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_monitor (.i_clock, .i_rst_n, .i_reset_pin, .i_wr,
    .i_addr, .i_wdata, .i_rx_count, .i_tx_count, .i_rx_trigger, .o_dtr_n, .o_rts_n, .o_user_output_two_n,
    .o_irq, .o_irq_oe, .o_rx_ready_n, .o_tx_ready_n, .o_tx_pin, .o_rx_serial);
`default_nettype wire

// >>> src/ucpc_pkg.sv
// package for the dual-channel pin control block
// assumes one clock domain and a simple strobe register port
package ucpc_pkg;
    // register offsets per channel (word index, channel b adds stride)
    localparam logic [3:0] UCPC_OFF_MCTL = 4'h0;
    localparam logic [3:0] UCPC_OFF_MSTAT = 4'h1;
    localparam logic [3:0] UCPC_OFF_IRQ_EN = 4'h2;
    localparam logic [3:0] UCPC_OFF_IST = 4'h3;
    localparam logic [3:0] UCPC_OFF_IMSK = 4'h4;
    localparam logic [3:0] UCPC_OFF_FST = 4'h5;
    localparam logic [3:0] UCPC_CH_STRIDE = 4'h8;
    // modem control fields
    localparam int UCPC_MCTL_DTR = 0;
    localparam int UCPC_MCTL_RTS = 1;
    localparam int UCPC_MCTL_OUT2 = 3;
    // modem status fields
    localparam int UCPC_MSTAT_CTS = 4;
    localparam int UCPC_MSTAT_DSR = 5;
    localparam int UCPC_MSTAT_RI = 6;
    localparam int UCPC_MSTAT_CD = 7;
    // reset values
    localparam logic [7:0] UCPC_MCTL_RST = 8'h00;
    localparam logic [7:0] UCPC_IRQ_EN_RST = 8'h00;
    localparam logic [7:0] UCPC_IMSK_RST = 8'h00;
    // status event bits: 0 rx ready, 1 tx ready, 2 modem change
    localparam int UCPC_EV_RX = 0;
    localparam int UCPC_EV_TX = 1;
    localparam int UCPC_EV_MDM = 2;
endpackage

// >>> src/ucpc_top.sv
// dual-channel modem pin, dma ready and interrupt control
// assumes fifo levels come from same-clock logic, modem pins are async
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - control bit3 set: irq driven, user out low
// - control bit3 clear: irq tristate, user out high
// - reset active high clears registers, sets outputs to idle levels
// - during reset tx disabled, rx ignored
// - rx ready low when characters reach trigger
// - rx ready high when empty/below trigger
// - tx ready low when a slot free
// - tx ready high when tx full
// - ready pins serve dma mode 0, 1
// - control bit0 one drives terminal ready low
// - cts reported in status bit4 and in the modem change event
// - each channel has independent pin state
// - control bit1 one drives rts low
// - irq needs bit3, enable, and condition
module ucpc_top
    import ucpc_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_reset_pin,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // fifo status from datapath, per channel
    input wire logic [9:0] i_rx_count,
    input wire logic [9:0] i_tx_count,
    input wire logic [9:0] i_rx_trigger,
    input wire logic [1:0] i_rx_line_err,
    input wire logic [1:0] i_tx_serial,
    input wire logic [1:0] i_rx_serial_pin,
    // modem inputs, active low, async
    input wire logic [1:0] i_cts_n,
    input wire logic [1:0] i_dsr_n,
    input wire logic [1:0] i_ri_n,
    input wire logic [1:0] i_carrier_detect_in_n,
    // modem and pin outputs
    output logic [1:0] o_dtr_n,
    output logic [1:0] o_rts_n,
    output logic [1:0] o_user_output_two_n,
    output logic [1:0] o_irq,
    output logic [1:0] o_irq_oe,
    output logic [1:0] o_rx_ready_n,
    output logic [1:0] o_tx_ready_n,
    output logic [1:0] o_tx_pin,
    output logic [1:0] o_rx_serial,
    output logic o_int
);
    initial begin
        // level fields are five bits wide per channel
        if (FIFO_DEPTH < 1 || FIFO_DEPTH > 31) begin
            $error("FIFO_DEPTH out of range");
        end
    end

    // which channel and offset an address hits
    function automatic logic hit(input logic [3:0] a, input int ch, input logic [3:0] off);
        hit = (a == (off + (ch == 1 ? UCPC_CH_STRIDE : 4'h0)));
    endfunction

    // reset pin synchroniser, combined reset
    logic rpin_s1_ff, rpin_s2_ff;
    logic rst;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rpin_s1_ff <= 1'b0;
            rpin_s2_ff <= 1'b0;
        end else begin
            rpin_s1_ff <= i_reset_pin;
            rpin_s2_ff <= rpin_s1_ff;
        end
    end
    assign rst = !i_rst_n || rpin_s2_ff;

    // modem input synchronisers
    logic [7:0] mdm_s1_ff, mdm_s2_ff, mdm_prev_ff;
    logic [1:0] rxs_s1_ff, rxs_s2_ff;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            mdm_s1_ff <= 8'hff;
            mdm_s2_ff <= 8'hff;
            rxs_s1_ff <= 2'h3;
            rxs_s2_ff <= 2'h3;
        end else begin
            mdm_s1_ff <= {i_carrier_detect_in_n, i_ri_n, i_dsr_n, i_cts_n};
            mdm_s2_ff <= mdm_s1_ff;
            rxs_s1_ff <= i_rx_serial_pin;
            rxs_s2_ff <= rxs_s1_ff;
        end
    end

    // per-channel registers
    logic [7:0] mctl_ff [2];
    logic [7:0] irq_en_ff [2];
    logic [7:0] imsk_ff [2];
    logic [7:0] ist_ff [2];
    logic [7:0] mstat [2];
    logic [2:0] ev [2];
    logic [1:0] rx_rdy, tx_rdy;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        // status view of modem pins, true polarity; cts also feeds the modem change event
        always_comb begin
            mstat[c] = 8'h00;
            mstat[c][UCPC_MSTAT_CTS] = !mdm_s2_ff[c];
            mstat[c][UCPC_MSTAT_DSR] = !mdm_s2_ff[2 + c];
            mstat[c][UCPC_MSTAT_RI] = !mdm_s2_ff[4 + c];
            mstat[c][UCPC_MSTAT_CD] = !mdm_s2_ff[6 + c];
        end
        // ready conditions
        assign rx_rdy[c] = (i_rx_count[5*c +: 5] != 5'h0_0) &&
            (i_rx_count[5*c +: 5] >= i_rx_trigger[5*c +: 5]);
        assign tx_rdy[c] = i_tx_count[5*c +: 5] < 5'(FIFO_DEPTH);
        // interrupt conditions
        assign ev[c][UCPC_EV_RX] = rx_rdy[c] || i_rx_line_err[c];
        assign ev[c][UCPC_EV_TX] = tx_rdy[c];
        assign ev[c][UCPC_EV_MDM] = mdm_prev_ff[c] != mdm_s2_ff[c] || mdm_prev_ff[2+c] != mdm_s2_ff[2+c] ||
            (mdm_s2_ff[4+c] && !mdm_prev_ff[4+c]) || mdm_prev_ff[6+c] != mdm_s2_ff[6+c];

        // modem control, irq enable and interrupt mask registers
        always_ff @(posedge i_clock) begin
            if (rst) begin
                mctl_ff[c] <= UCPC_MCTL_RST;
                irq_en_ff[c] <= UCPC_IRQ_EN_RST;
                imsk_ff[c] <= UCPC_IMSK_RST;
            end else if (i_wr) begin
                if (hit(i_addr, c, UCPC_OFF_MCTL)) mctl_ff[c] <= i_wdata;
                if (hit(i_addr, c, UCPC_OFF_IRQ_EN)) irq_en_ff[c] <= i_wdata;
                if (hit(i_addr, c, UCPC_OFF_IMSK)) imsk_ff[c] <= i_wdata;
            end
        end

        // sticky status, set wins over read clear
        always_ff @(posedge i_clock) begin
            if (rst) begin
                ist_ff[c] <= 8'h00;
            end else begin
                ist_ff[c] <= ((i_rd && hit(i_addr, c, UCPC_OFF_IST)) ? 8'h00 : ist_ff[c]) |
                    {5'h0_0, ev[c]}; // events latch regardless of enables
            end
        end

        // pin outputs
        always_ff @(posedge i_clock) begin
            if (rst) begin
                o_dtr_n[c] <= 1'b1;
                o_rts_n[c] <= 1'b1;
                o_user_output_two_n[c] <= 1'b1;
                o_irq[c] <= 1'b0;
                o_irq_oe[c] <= 1'b0;
                o_rx_ready_n[c] <= 1'b1;
                o_tx_ready_n[c] <= 1'b1;
                o_tx_pin[c] <= 1'b1;
                o_rx_serial[c] <= 1'b1;
            end else begin
                o_dtr_n[c] <= !mctl_ff[c][UCPC_MCTL_DTR];
                o_rts_n[c] <= !mctl_ff[c][UCPC_MCTL_RTS];
                o_user_output_two_n[c] <= !mctl_ff[c][UCPC_MCTL_OUT2];
                o_irq_oe[c] <= mctl_ff[c][UCPC_MCTL_OUT2];
                o_irq[c] <= mctl_ff[c][UCPC_MCTL_OUT2] && |(ev[c] & irq_en_ff[c][2:0]);
                o_rx_ready_n[c] <= !rx_rdy[c];
                o_tx_ready_n[c] <= !tx_rdy[c];
                o_tx_pin[c] <= i_tx_serial[c];
                o_rx_serial[c] <= rxs_s2_ff[c];
            end
        end
    end

    // previous modem sample for change detection
    always_ff @(posedge i_clock) begin
        if (rst) begin
            mdm_prev_ff <= 8'hff;
        end else begin
            mdm_prev_ff <= mdm_s2_ff;
        end
    end

    // read data one cycle after strobe
    always_ff @(posedge i_clock) begin
        if (rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= 8'h00;
            for (int c = 0; c < 2; c++) begin
                if (hit(i_addr, c, UCPC_OFF_MCTL)) o_rdata <= mctl_ff[c];
                if (hit(i_addr, c, UCPC_OFF_MSTAT)) o_rdata <= mstat[c];
                if (hit(i_addr, c, UCPC_OFF_IRQ_EN)) o_rdata <= irq_en_ff[c];
                if (hit(i_addr, c, UCPC_OFF_IST)) o_rdata <= ist_ff[c];
                if (hit(i_addr, c, UCPC_OFF_IMSK)) o_rdata <= imsk_ff[c];
                if (hit(i_addr, c, UCPC_OFF_FST)) o_rdata <= {6'h0_0, tx_rdy[c], rx_rdy[c]};
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // combined level interrupt
    always_ff @(posedge i_clock) begin
        if (rst) begin
            o_int <= 1'b0;
        end else begin
            o_int <= |(ist_ff[0] & imsk_ff[0]) || |(ist_ff[1] & imsk_ff[1]);
        end
    end
endmodule

`default_nettype wire
